// *** src/ccss_pkg.sv ***
// Constants, register map and types of the CPU clock source switcher.
// Assumes a single 200 MHz clock and firmware access over AXI4-Lite.
package ccss_pkg;
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_RUN = 8'h04;
   localparam logic [7:0] ADDR_SYS = 8'h08;
   localparam logic [7:0] ADDR_PLL = 8'h0C;
   localparam logic [7:0] ADDR_PCLK = 8'h10;
   localparam logic [7:0] ADDR_STSEL = 8'h14;
   localparam logic [7:0] ADDR_STCNT = 8'h18;
   localparam logic [7:0] ADDR_STAT = 8'h1C;
   localparam logic [7:0] ADDR_CFG = 8'h20;
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [1:0] RST_RUN = 2'h1;
   localparam logic [2:0] RST_STSEL = 3'h7;
   localparam logic [1:0] DIV_BY2 = 2'h0;
   localparam logic [1:0] DIV_BY4 = 2'h1;
   localparam logic [1:0] DIV_BY8 = 2'h2;
   localparam logic [1:0] DIV_UNUSED = 2'h3;
   localparam logic [8:0] CYC_TO_PLL_FAST = 9'h002;
   localparam logic [8:0] CYC_TO_PLL_SLOW = 9'h00A;
   localparam logic [8:0] CYC_PLL_OSC_SLOW = 9'h100;
   localparam logic [8:0] CYC_PLL_OSC_FAST = 9'h010;
   localparam logic [8:0] CYC_PLL_MAIN_D2 = 9'h008;
   localparam logic [8:0] CYC_PLL_MAIN_D4 = 9'h004;
   localparam logic [8:0] CYC_PLL_MAIN_D8 = 9'h002;
   localparam logic [8:0] CYC_OTHER = 9'h002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      SRC_ONCHIP = 3'b000,
      SRC_MAIN = 3'b001,
      SRC_SUB = 3'b010,
      SRC_PLL2 = 3'b011,
      SRC_PLL4 = 3'b100,
      SRC_PLL8 = 3'b101
   } ccss_src_e;
endpackage : ccss_pkg

// *** src/ccss_switch_timer.sv ***
// Down-counter that times one clock source switch.
// Assumes load is a one-cycle pulse given only while idle.
`timescale 1ns/10ps
module ccss_switch_timer
   import ccss_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [8:0] load_val,
   output logic busy,
   output logic done
);
   logic [8:0] cnt_ff;
   logic busy_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 9'h000;
         busy_ff <= 1'b0;
      end else if (load) begin
         cnt_ff <= load_val;
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 9'h001;
         busy_ff <= (cnt_ff != 9'h001);
      end
   end

   assign busy = busy_ff;
   assign done = busy_ff && (cnt_ff == 9'h001);
endmodule : ccss_switch_timer

// *** src/ccss_top.sv ***
// CPU clock source switcher with its AXI4-Lite register file.
// Assumes source ticks arrive asynchronously on pins; CPU halt request is synchronous.
`timescale 1ns/10ps
module ccss_top
   import ccss_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] src_tick_pin,
   input wire logic halt_req,
   input wire logic wake_req,
   output logic cpu_tick,
   output logic [2:0] cpu_src,
   output logic cpu_halted
);
   ////////////////////////////////////////////////////////////////////////////
   // Register bus.
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic wr_go, rd_go, wr_hit, rd_hit;
   logic [31:0] rd_val;
   logic [2:0] mode_ff, stsel_ff;
   logic mode_written_ff;
   logic [1:0] run_ff, sys_ff, div_ff;
   logic [2:0] pll_ff;
   logic psel_ff, top_bit_ff;
   logic [7:0] stcnt_ff;
   logic [2:0] cpu_src_ff, pend_src_ff;
   logic busy_stat_ff, halted_ff, cpu_tick_ff;

   assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
   assign rd_go = s_axi_arvalid && arready_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bresp_ff <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            awready_ff <= 1'b1;
         end
         if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            wready_ff <= 1'b1;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      case (awaddr_ff)
         ADDR_MODE, ADDR_RUN, ADDR_SYS, ADDR_PLL, ADDR_PCLK, ADDR_STSEL, ADDR_CFG: wr_hit = 1'b1;
         ADDR_STCNT, ADDR_STAT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ADDR_MODE: rd_val[2:0] = mode_ff;
         ADDR_RUN: rd_val[1:0] = run_ff;
         ADDR_SYS: rd_val[1:0] = sys_ff;
         ADDR_PLL: rd_val[2:0] = pll_ff;
         ADDR_PCLK: rd_val[2:0] = {div_ff, psel_ff};
         ADDR_STSEL: rd_val[2:0] = stsel_ff;
         ADDR_STCNT: rd_val[7:0] = stcnt_ff;
         ADDR_STAT: rd_val[4:0] = {halted_ff, busy_stat_ff, cpu_src_ff};
         ADDR_CFG: rd_val[0] = top_bit_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (rd_go) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= RST_MODE;
         mode_written_ff <= 1'b0;
      end else if (wr_go && awaddr_ff == ADDR_MODE && !mode_written_ff) begin
         mode_written_ff <= 1'b1;
         if (wstrb_ff[0]) begin
            mode_ff <= wdata_ff[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_ff <= RST_RUN;
         sys_ff <= 2'h0;
         pll_ff <= 3'h0;
         psel_ff <= 1'b0;
         div_ff <= DIV_BY2;
         stsel_ff <= RST_STSEL;
         top_bit_ff <= 1'b0;
      end else if (wr_go && wstrb_ff[0]) begin
         case (awaddr_ff)
            ADDR_RUN: run_ff <= wdata_ff[1:0];
            ADDR_SYS: sys_ff <= wdata_ff[1:0];
            ADDR_PLL: pll_ff <= wdata_ff[2:0];
            ADDR_PCLK: begin
               psel_ff <= wdata_ff[0];
               if (wdata_ff[2:1] != DIV_UNUSED) begin
                  div_ff <= wdata_ff[2:1];
               end
            end
            ADDR_STSEL: stsel_ff <= wdata_ff[2:0];
            ADDR_CFG: top_bit_ff <= wdata_ff[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stcnt_ff <= 8'h00;
      end else if (run_ff[0] || !mode_ff[1] || mode_ff[0]) begin
         stcnt_ff <= 8'h00;
      end else if (stcnt_ff != 8'hFF) begin
         stcnt_ff <= stcnt_ff + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source ticks, PLL division and switching.
   logic [3:0] sync1_ff, sync2_ff;
   logic [2:0] pdiv_ff;
   logic [2:0] target, pll_src;
   logic [8:0] sw_cycles;
   logic sw_start, tmr_busy, tmr_done, sel_tick;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= src_tick_pin[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pdiv_ff <= 3'h0;
      end else if (sync2_ff[3]) begin
         pdiv_ff <= pdiv_ff + 3'h1;
      end
   end

   always_comb begin
      case (div_ff)
         DIV_BY2: pll_src = SRC_PLL2;
         DIV_BY4: pll_src = SRC_PLL4;
         default: pll_src = SRC_PLL8;
      endcase
      if (sys_ff[1]) begin
         target = SRC_SUB;
      end else if (psel_ff) begin
         target = pll_src;
      end else if (sys_ff[0]) begin
         target = SRC_MAIN;
      end else begin
         target = SRC_ONCHIP;
      end
   end

   always_comb begin
      sw_cycles = CYC_OTHER;
      if (target >= SRC_PLL2) begin
         sw_cycles = top_bit_ff ? CYC_TO_PLL_FAST : CYC_TO_PLL_SLOW;
      end else if (cpu_src_ff >= SRC_PLL2 && target == SRC_ONCHIP) begin
         sw_cycles = top_bit_ff ? CYC_PLL_OSC_FAST : CYC_PLL_OSC_SLOW;
      end else if (cpu_src_ff >= SRC_PLL2 && target == SRC_MAIN) begin
         case (cpu_src_ff)
            SRC_PLL2: sw_cycles = CYC_PLL_MAIN_D2;
            SRC_PLL4: sw_cycles = CYC_PLL_MAIN_D4;
            default: sw_cycles = CYC_PLL_MAIN_D8;
         endcase
      end
   end

   assign sw_start = (target != cpu_src_ff) && !tmr_busy && !halted_ff;

   ccss_switch_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(sw_start),
      .load_val(sw_cycles),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_src_ff <= SRC_ONCHIP;
         pend_src_ff <= SRC_ONCHIP;
         busy_stat_ff <= 1'b0;
      end else begin
         busy_stat_ff <= tmr_busy;
         if (sw_start) begin
            pend_src_ff <= target;
         end
         if (tmr_done) begin
            cpu_src_ff <= pend_src_ff;
         end
      end
   end

   always_comb begin
      case (cpu_src_ff)
         SRC_ONCHIP: sel_tick = sync2_ff[0];
         SRC_MAIN: sel_tick = sync2_ff[1];
         SRC_SUB: sel_tick = sync2_ff[2];
         SRC_PLL2: sel_tick = sync2_ff[3] && pdiv_ff[0];
         SRC_PLL4: sel_tick = sync2_ff[3] && (pdiv_ff[1:0] == 2'h3);
         default: sel_tick = sync2_ff[3] && (pdiv_ff == 3'h7);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halted_ff <= 1'b0;
         cpu_tick_ff <= 1'b0;
      end else begin
         if (halt_req && !tmr_busy && !sw_start) begin
            halted_ff <= 1'b1;
         end else if (wake_req) begin
            halted_ff <= 1'b0;
         end
         cpu_tick_ff <= sel_tick && !halted_ff;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign cpu_tick = cpu_tick_ff;
   assign cpu_src = cpu_src_ff;
   assign cpu_halted = halted_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence to_pll_fast_s;
      sw_start && target >= SRC_PLL2 && top_bit_ff;
   endsequence
   sequence to_pll_slow_s;
      sw_start && target >= SRC_PLL2 && !top_bit_ff;
   endsequence

   mode_write_once_a: assert property (mode_written_ff |=> $stable(mode_ff))
      else $error("mode control changed after its single write");
   div_code_a: assert property (div_ff != DIV_UNUSED)
      else $error("unused division code held");
   pll_fast_a: assert property (to_pll_fast_s |-> ##3 cpu_src_ff == $past(target, 3))
      else $error("fast switch to PLL not complete in time");
   pll_slow_a: assert property (to_pll_slow_s |-> ##11 cpu_src_ff == $past(target, 11))
      else $error("slow switch to PLL not complete in time");
   pll_osc_slow_a: assert property (sw_start && cpu_src_ff >= SRC_PLL2 && target == SRC_ONCHIP
      && !top_bit_ff |-> ##256 cpu_src_ff != SRC_ONCHIP ##1 cpu_src_ff == SRC_ONCHIP)
      else $error("leave PLL to oscillator timing wrong");
   pll_main_d2_a: assert property (sw_start && cpu_src_ff == SRC_PLL2 && target == SRC_MAIN
      |-> ##8 cpu_src_ff == SRC_PLL2 ##1 cpu_src_ff == SRC_MAIN)
      else $error("leave PLL to main timing wrong");
   hold_old_a: assert property (tmr_busy && !tmr_done |=> $stable(cpu_src_ff))
      else $error("source changed before switch completed");
   halt_keep_a: assert property (halted_ff |=> !cpu_tick_ff && $stable(cpu_src_ff))
      else $error("halt changed clock state");
   status_read_a: assert property (rd_go && s_axi_araddr == ADDR_STAT
      |=> s_axi_rdata[2:0] == $past(cpu_src_ff))
      else $error("status does not show the current source");
   bresp_hold_a: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff)
      else $error("write response dropped early");
endmodule : ccss_top

// *** testbench/cpu_clock_source_switcher_test.sv ***
// Self-checking bench for the CPU clock source switcher.
// Assumes ccss_top with AXI4-Lite registers and one 200 MHz clock.
`timescale 1ns/10ps
module cpu_clock_source_switcher_test;
   import ccss_pkg::*;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, src_tick_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, halt_req, wake_req, cpu_tick, cpu_halted;
   logic [2:0] cpu_src;
   logic [31:0] rd;
   int fails, total_checks, cyc, n;
   localparam int CYC_PER_US = 200;
   ////////////////////////////////////////////////////////////////////////////
   ccss_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .src_tick_pin(src_tick_pin), .halt_req(halt_req),
      .wake_req(wake_req), .cpu_tick(cpu_tick), .cpu_src(cpu_src),
      .cpu_halted(cpu_halted));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Source pins toggle every third cycle to feed ticks.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc % 3 == 0) begin
         src_tick_pin <= ~src_tick_pin;
      end
      if (cyc == 40000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check_val
   task automatic check_span(input string nm, input int lo, input int hi, input int got);
      total_checks = total_checks + 1;
      if (got < lo || got > hi) begin
         fails = fails + 1;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask : check_span
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] exp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      check_val("bresp", {30'h0, exp}, {30'h0, s_axi_bresp});
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, input logic [1:0] exp, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      check_val("rresp", {30'h0, exp}, {30'h0, s_axi_rresp});
   endtask : axi_read
   task automatic read_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, RESP_OKAY, rd);
      check_val(nm, exp, rd);
   endtask : read_chk
   task automatic wait_us(input int us);
      repeat (us * CYC_PER_US) @(posedge aclk);
   endtask : wait_us
   // Writes a switching register and times the arrival of the new source.
   task automatic switch_to(input logic [7:0] a, input logic [31:0] d, input logic [2:0] s,
      input int lo, input int hi);
      axi_write(a, d, 4'h1, RESP_OKAY);
      n = 0;
      while (cpu_src !== s && n < hi + 4) begin
         @(posedge aclk);
         n = n + 1;
      end
      check_val("cpu_src", {29'h0, s}, {29'h0, cpu_src});
      check_span("switch cycles", lo, hi, n);
   endtask : switch_to
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      total_checks = 0;
      cyc = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      src_tick_pin = 4'h0;
      halt_req = 1'b0;
      wake_req = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      read_chk("status", ADDR_STAT, 32'h0000_0000);
      read_chk("run", ADDR_RUN, 32'h0000_0001);
      read_chk("stsel", ADDR_STSEL, 32'h0000_0007);
      read_chk("cfg", ADDR_CFG, 32'h0000_0000);
      axi_read(8'h24, RESP_SLVERR, rd);
      axi_write(8'h24, 32'h0000_0001, 4'h1, RESP_SLVERR);
      axi_write(ADDR_MODE, 32'h0000_0006, 4'h1, RESP_OKAY);
      axi_write(ADDR_MODE, 32'h0000_0001, 4'h1, RESP_OKAY);
      read_chk("mode", ADDR_MODE, 32'h0000_0006);
      axi_write(ADDR_RUN, 32'h0000_0000, 4'h1, RESP_OKAY);
      repeat (300) @(posedge aclk);
      read_chk("stcnt", ADDR_STCNT, 32'h0000_00FF);
      axi_write(ADDR_PLL, 32'h0000_0006, 4'h1, RESP_OKAY);
      wait_us(1);
      axi_write(ADDR_PLL, 32'h0000_0007, 4'h1, RESP_OKAY);
      wait_us(40);
      read_chk("pll", ADDR_PLL, 32'h0000_0007);
      switch_to(ADDR_PCLK, 32'h0000_0003, SRC_PLL4, 8, 13);
      read_chk("status", ADDR_STAT, 32'h0000_0004);
      axi_write(ADDR_PCLK, 32'h0000_0007, 4'h1, RESP_OKAY);
      repeat (20) @(posedge aclk);
      check_val("cpu_src", {29'h0, SRC_PLL4}, {29'h0, cpu_src});
      switch_to(ADDR_PCLK, 32'h0000_0002, SRC_ONCHIP, 254, 259);
      axi_write(ADDR_CFG, 32'h0000_0001, 4'h1, RESP_OKAY);
      switch_to(ADDR_SYS, 32'h0000_0001, SRC_MAIN, 0, 5);
      for (int d = 0; d < 3; d++) begin
         switch_to(ADDR_PCLK, 32'(d * 2 + 1), 3'(3 + d), 0, 5);
         if (d == 0) begin
            wait_us(65);
         end
         switch_to(ADDR_PCLK, 32'(d * 2), SRC_MAIN, (8 >> d) - 2, (8 >> d) + 3);
      end
      switch_to(ADDR_SYS, 32'h0000_0000, SRC_ONCHIP, 0, 5);
      switch_to(ADDR_PCLK, 32'h0000_0001, SRC_PLL2, 0, 5);
      switch_to(ADDR_PCLK, 32'h0000_0000, SRC_ONCHIP, 14, 19);
      switch_to(ADDR_SYS, 32'h0000_0002, SRC_SUB, 0, 5);
      switch_to(ADDR_SYS, 32'h0000_0000, SRC_ONCHIP, 0, 5);
      switch_to(ADDR_PCLK, 32'h0000_0005, SRC_PLL8, 0, 5);
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      repeat (4) @(posedge aclk);
      n = 0;
      repeat (30) begin
         @(posedge aclk);
         n = n + (cpu_tick === 1'b1 ? 1 : 0);
      end
      check_val("halted", 32'h1, {31'h0, cpu_halted});
      check_val("halt ticks", 32'h0, n);
      read_chk("status", ADDR_STAT, 32'h0000_0015);
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      n = 0;
      repeat (60) begin
         @(posedge aclk);
         n = n + (cpu_tick === 1'b1 ? 1 : 0);
      end
      check_val("halted", 32'h0, {31'h0, cpu_halted});
      check_span("run ticks", 1, 60, n);
      check_val("cpu_src", {29'h0, SRC_PLL8}, {29'h0, cpu_src});
      axi_write(ADDR_SYS, 32'h0000_0001, 4'h1, RESP_OKAY);
      switch_to(ADDR_PCLK, 32'h0000_0004, SRC_MAIN, 0, 5);
      axi_write(ADDR_PLL, 32'h0000_0000, 4'h1, RESP_OKAY);
      read_chk("pll", ADDR_PLL, 32'h0000_0000);
      finish_test();
   end
endmodule : cpu_clock_source_switcher_test
